// ---- slc_defines.svh ----
/*
  Constants of the serial link control block: register offsets, field positions,
  reset values, frame layout and timing counts.
  Assumes inclusion by bare name from every file that needs the numbers.
*/
`ifndef SLC_DEFINES_SVH
`define SLC_DEFINES_SVH

// Clock and frame layout
`define SLC_MCLK_MHZ        10
`define SLC_PIX_W           24
`define SLC_BIT_CYC         2
`define SLC_TX_LAST_BIT     5'h19
`define SLC_RX_PRE_STOP     6'h31
`define SLC_RX_STOP_CNT     6'h32
`define SLC_RX_FIRST_DATA   6'h02
`define SLC_RX_LAST_DATA    6'h30

// Register map, byte addresses on a 32-bit bus
`define SLC_CTRL_OFS        4'h0
`define SLC_STAT_OFS        4'h4
`define SLC_RXWORD_OFS      4'h8
`define SLC_CTRL_RST        7'h6a
`define SLC_STAT_TXLOCK     0
`define SLC_STAT_RXLOCK     1
`define SLC_STAT_INRDY      2
`define SLC_STAT_RXSTATE    4

// Payload whitening pattern
`define SLC_SCR_MASK        24'h5a_c396

// Lock and recovered clock timing
`define SLC_TX_LOCK_EDGES   4'h8
`define SLC_TX_TIMEOUT_NS   2000
`define SLC_TX_TIMEOUT_CYC  ((`SLC_TX_TIMEOUT_NS * `SLC_MCLK_MHZ) / 1000)
`define SLC_RX_LOCK_LAST    3'h3
`define SLC_RX_IDLE_NS      20000
`define SLC_RX_IDLE_CYC     ((`SLC_RX_IDLE_NS * `SLC_MCLK_MHZ) / 1000)
`define SLC_RCLK_HALF       5'h8

`endif

// ---- slc_pkg.sv ----
/*
  Types of the serial link control block: control word, synchronised pin bundle,
  receive framing states and the state record of the main module.
  Assumes slc_defines.svh is on the include path.
*/
`include "slc_defines.svh"

package slc_pkg;

  typedef struct packed {
    logic rx_edge_select;
    logic des_output_enable;
    logic des_powerdown_n;
    logic tx_edge_select;
    logic scramble_off;
    logic ser_output_enable;
    logic ser_powerdown_n;
  } slc_ctrl_s;

  typedef struct packed {
    logic                     rx;
    logic                     pclk;
    logic [`SLC_PIX_W-1:0]    data;
  } slc_async_s;

  // Gray order along hunt, data, stop
  typedef enum logic [1:0] {
    RX_HUNT = 2'h0,
    RX_DATA = 2'h1,
    RX_STOP = 2'h3
  } slc_rx_e;

  typedef struct packed {
    slc_ctrl_s                ctrl;
    logic                     wait_q;
    logic [31:0]              rdata;
    logic                     pclk_d;
    logic [3:0]               tx_edges;
    logic [7:0]               tx_timer;
    logic                     tx_locked;
    logic                     tx_busy;
    logic                     tx_phase;
    logic [4:0]               tx_bit;
    logic [24:0]              tx_sh;
    logic                     ser_out;
    logic                     ser_out_oe_n;
    slc_rx_e                  rx_state;
    logic                     rx_prev;
    logic [5:0]               rx_cnt;
    logic [`SLC_PIX_W-1:0]    rx_sh;
    logic [7:0]               rx_idle;
    logic [2:0]               rx_good;
    logic                     rx_locked;
    logic [`SLC_PIX_W-1:0]    rx_word;
    logic [`SLC_PIX_W-1:0]    des_parallel_out;
    logic                     rclk;
    logic [4:0]               rclk_cnt;
    logic                     des_data_oe_n;
    logic                     lock_out;
    logic                     lock_oe_n;
  } slc_state_s;

endpackage

// ---- slc_sync.sv ----
/*
  Two-flop synchroniser for a bundle of pins.
  Assumes each bit is a level that may be sampled independently.
*/
`timescale 1ns/100ps

module slc_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] ff2;
    logic [W-1:0] ff1;
  } slc_sync_s;

  slc_sync_s st;
  slc_sync_s next_st;

  // First stage feeds the second only
  always_comb begin
    next_st     = st;
    next_st.ff1 = d;
    next_st.ff2 = st.ff1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.ff2;

endmodule

// ---- slc_fifo2.sv ----
/*
  Small flop-based FIFO with valid/ready on both sides.
  Assumes a single clock; in_ready is registered and drops when full.
*/
`timescale 1ns/100ps

module slc_fifo2 #(
  parameter int W     = 24,
  parameter int DEPTH = 2
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    in_ready;
  } slc_fifo_s;

  slc_fifo_s st;
  slc_fifo_s next_st;
  logic      push;
  logic      pop;

  always_comb begin
    next_st = st;
    push    = in_valid & st.in_ready;
    pop     = (st.cnt != '0) & out_ready;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + AW'(1);
    end
    if (pop) begin
      next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + AW'(1);
    end
    next_st.cnt      = st.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    // Full only when every slot is held, so a stalled drain really fills it
    next_st.in_ready = (next_st.cnt != (AW + 1)'(DEPTH));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st          <= '0;
      st.in_ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready  = st.in_ready;
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rp];

endmodule

// ---- slc_link_ctrl.sv ----
/*
  Serial link control: pixel capture, framed serial transmit with embedded clock,
  receive framing with lock detection, recovered clock and parallel outputs,
  tri-state gating of the serial, data and lock outputs, and an Avalon-MM control/status slave.
  Assumes mclk at 10 MHz, pixel clock and serial input from other domains,
  and the far end sending frames at the same bit rate.
*/
`timescale 1ns/100ps
`include "slc_defines.svh"

module slc_link_ctrl
  import slc_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  tx_pixel_clock,
  input  wire logic [`SLC_PIX_W-1:0] ser_din,
  output logic                       ser_in_ready,
  output logic                       ser_out,
  output logic                       ser_out_oe_n,
  input  wire logic                  serial_rx,
  output logic      [`SLC_PIX_W-1:0] des_parallel_out,
  output logic                       rclk_out,
  output logic                       des_data_oe_n,
  output logic                       lock_out,
  output logic                       lock_oe_n
);

  localparam logic [7:0] TX_TIMEOUT = 8'(`SLC_TX_TIMEOUT_CYC);
  localparam logic [7:0] RX_IDLE    = 8'(`SLC_RX_IDLE_CYC);
  localparam int         RCLK_DLY   = `SLC_RCLK_HALF;

  slc_state_s            st;
  slc_state_s            next_st;
  slc_async_s            async_in;
  slc_async_s            async_q;
  logic                  fifo_in_valid;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  fifo_out_ready;
  logic [`SLC_PIX_W-1:0] fifo_out_data;
  logic                  pix_rise;
  logic                  pix_fall;
  logic                  ser_active;
  logic                  frame_good;
  logic                  frame_bad;
  logic                  new_word;
  logic [`SLC_PIX_W-1:0] rx_dec;
  logic [31:0]           stat;

  assign async_in = '{rx: serial_rx, pclk: tx_pixel_clock, data: ser_din};

  slc_sync #(
    .W ($bits(slc_async_s))
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    (async_in),
    .q    (async_q)
  );

  // Two entries absorb a pixel that arrives while a frame is still on the line
  slc_fifo2 #(
    .W     (`SLC_PIX_W),
    .DEPTH (2)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (async_q.data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    next_st = st;
    stat    = '0;

    // Avalon slave: one wait cycle, then the access completes
    next_st.wait_q = ~((avs_read | avs_write) & st.wait_q);
    stat[`SLC_STAT_TXLOCK]        = st.tx_locked;
    stat[`SLC_STAT_RXLOCK]        = st.rx_locked;
    stat[`SLC_STAT_INRDY]         = fifo_in_ready;
    stat[`SLC_STAT_RXSTATE +: 2]  = st.rx_state;
    if (avs_read & st.wait_q) begin
      case (avs_address)
        `SLC_CTRL_OFS:   next_st.rdata = {25'h0, st.ctrl};
        `SLC_STAT_OFS:   next_st.rdata = stat;
        `SLC_RXWORD_OFS: next_st.rdata = {8'h0, st.rx_word};
        default:         next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write & ~st.wait_q & avs_byteenable[0] & (avs_address == `SLC_CTRL_OFS)) begin
      next_st.ctrl = slc_ctrl_s'(avs_writedata[6:0]);
    end

    // Pixel clock edges
    next_st.pclk_d = async_q.pclk;
    pix_rise       = async_q.pclk & ~st.pclk_d;
    pix_fall       = ~async_q.pclk & st.pclk_d;
    fifo_in_valid  = (st.ctrl.tx_edge_select ? pix_rise : pix_fall) & st.ctrl.ser_powerdown_n;

    // Transmit lock: a steady run of pixel clock edges, lost on a stall
    if (!st.ctrl.ser_powerdown_n) begin
      next_st.tx_edges  = '0;
      next_st.tx_timer  = '0;
      next_st.tx_locked = 1'b0;
    end else if (pix_rise) begin
      next_st.tx_timer = '0;
      if (st.tx_edges != `SLC_TX_LOCK_EDGES) begin
        next_st.tx_edges = st.tx_edges + 4'h1;
      end else begin
        next_st.tx_locked = 1'b1;
      end
    end else if (st.tx_timer == TX_TIMEOUT) begin
      next_st.tx_edges  = '0;
      next_st.tx_locked = 1'b0;
    end else begin
      next_st.tx_timer = st.tx_timer + 8'h01;
    end

    // Transmit framing: start 1, 24 payload bits LSB first, stop 0
    // Next-cycle enables, so no frame opens in the cycle that the output floats
    ser_active     = next_st.ctrl.ser_powerdown_n & next_st.ctrl.ser_output_enable & next_st.tx_locked;
    fifo_out_ready = ser_active & ~st.tx_busy;
    if (!ser_active) begin
      next_st.tx_busy = 1'b0;
      next_st.ser_out = 1'b0;
    end else if (!st.tx_busy) begin
      if (fifo_out_valid) begin
        next_st.tx_busy  = 1'b1;
        next_st.tx_phase = 1'b0;
        next_st.tx_bit   = '0;
        next_st.ser_out  = 1'b1;
        next_st.tx_sh    = {1'b0, st.ctrl.scramble_off ? fifo_out_data
                                                       : fifo_out_data ^ `SLC_SCR_MASK};
      end
    end else begin
      next_st.tx_phase = ~st.tx_phase;
      if (st.tx_phase) begin
        if (st.tx_bit == `SLC_TX_LAST_BIT) begin
          next_st.tx_busy = 1'b0;
        end else begin
          next_st.ser_out = st.tx_sh[0];
          next_st.tx_sh   = {1'b0, st.tx_sh[24:1]};
          next_st.tx_bit  = st.tx_bit + 5'h01;
        end
      end
    end
    next_st.ser_out_oe_n = ~(next_st.ctrl.ser_powerdown_n & next_st.ctrl.ser_output_enable
                             & next_st.tx_locked);

    // Receive framing: hunt for the clock rise, sample mid-bit
    next_st.rx_prev = async_q.rx;
    frame_good      = 1'b0;
    frame_bad       = 1'b0;
    case (st.rx_state)
      RX_HUNT: begin
        if (async_q.rx & ~st.rx_prev) begin
          next_st.rx_state = RX_DATA;
          next_st.rx_cnt   = '0;
          next_st.rx_idle  = '0;
        end else if (st.rx_idle != RX_IDLE) begin
          next_st.rx_idle = st.rx_idle + 8'h01;
        end
      end
      RX_DATA: begin
        next_st.rx_cnt = st.rx_cnt + 6'h01;
        if ((st.rx_cnt == 6'h00) && !async_q.rx) begin
          next_st.rx_state = RX_HUNT;
        end else begin
          if (!st.rx_cnt[0] && (st.rx_cnt >= `SLC_RX_FIRST_DATA) && (st.rx_cnt <= `SLC_RX_LAST_DATA)) begin
            next_st.rx_sh = {async_q.rx, st.rx_sh[`SLC_PIX_W-1:1]};
          end
          if (st.rx_cnt == `SLC_RX_PRE_STOP) begin
            next_st.rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        next_st.rx_state = RX_HUNT;
        next_st.rx_idle  = '0;
        frame_good       = ~async_q.rx;
        frame_bad        = async_q.rx;
      end
      default: begin
        next_st.rx_state = RX_HUNT;
      end
    endcase

    // Receive lock: several good stop bits in a row; a bad stop bit or silence drops it
    if (!st.ctrl.des_powerdown_n) begin
      next_st.rx_good   = '0;
      next_st.rx_locked = 1'b0;
      next_st.rx_state  = RX_HUNT;
    end else if (frame_bad || (st.rx_idle == RX_IDLE)) begin
      next_st.rx_good   = '0;
      next_st.rx_locked = 1'b0;
    end else if (frame_good) begin
      if (st.rx_good == `SLC_RX_LOCK_LAST) begin
        next_st.rx_locked = 1'b1;
      end else begin
        next_st.rx_good = st.rx_good + 3'h1;
      end
    end

    // Descramble and present; outputs freeze while unlocked
    rx_dec = st.ctrl.scramble_off ? st.rx_sh : st.rx_sh ^ `SLC_SCR_MASK;
    if (frame_good & st.ctrl.des_powerdown_n) begin
      next_st.rx_word = rx_dec;
    end
    new_word = frame_good & next_st.rx_locked;
    if (new_word) begin
      next_st.des_parallel_out = rx_dec;
      next_st.rclk             = ~st.ctrl.rx_edge_select;
      next_st.rclk_cnt         = `SLC_RCLK_HALF;
    end else if (st.rclk_cnt != '0) begin
      next_st.rclk_cnt = st.rclk_cnt - 5'h01;
      if (st.rclk_cnt == 5'h01) begin
        next_st.rclk = st.ctrl.rx_edge_select;
      end
    end

    // Output gating; lock stays visible with output-enable low
    next_st.des_data_oe_n = ~(next_st.ctrl.des_powerdown_n & next_st.ctrl.des_output_enable
                              & next_st.rx_locked);
    next_st.lock_oe_n     = ~next_st.ctrl.des_powerdown_n;
    next_st.lock_out      = next_st.rx_locked;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st               <= '0;
      st.ctrl          <= `SLC_CTRL_RST;
      st.wait_q        <= 1'b1;
      st.ser_out_oe_n  <= 1'b1;
      st.des_data_oe_n <= 1'b1;
      st.lock_oe_n     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata     = st.rdata;
  assign avs_waitrequest  = st.wait_q;
  assign ser_in_ready     = fifo_in_ready;
  assign ser_out          = st.ser_out;
  assign ser_out_oe_n     = st.ser_out_oe_n;
  assign des_parallel_out = st.des_parallel_out;
  assign rclk_out         = st.rclk;
  assign des_data_oe_n    = st.des_data_oe_n;
  assign lock_out         = st.lock_out;
  assign lock_oe_n        = st.lock_oe_n;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_ser_hiz_gate: assert property (
    !(st.ctrl.ser_powerdown_n && st.ctrl.ser_output_enable && st.tx_locked) |-> st.ser_out_oe_n)
    else $error("serial output driven while not powered, enabled and locked");

  a_ser_start_bit: assert property (
    $rose(st.tx_busy) |-> st.ser_out && !st.ser_out_oe_n ##2 st.ser_out == $past(st.tx_sh[0], 2))
    else $error("frame does not open with clock bit then first payload bit");

  a_tx_scramble_map: assert property (
    $rose(st.tx_busy) |-> st.tx_sh[23:0] == ($past(st.ctrl.scramble_off) ? $past(fifo_out_data)
                                             : ($past(fifo_out_data) ^ `SLC_SCR_MASK)))
    else $error("payload coding does not follow scramble-off");

  a_pixel_edge_sel: assert property (
    fifo_in_valid |-> (async_q.pclk != st.pclk_d) && (async_q.pclk == st.ctrl.tx_edge_select))
    else $error("pixel captured on the wrong clock edge");

  a_des_pd_float: assert property (
    !st.ctrl.des_powerdown_n |-> st.lock_oe_n && st.des_data_oe_n)
    else $error("receiver output driven in power-down");

  a_des_oe_lock: assert property (
    (st.ctrl.des_powerdown_n && !st.ctrl.des_output_enable)
      |-> st.des_data_oe_n && !st.lock_oe_n && (st.lock_out == st.rx_locked))
    else $error("output-enable low must float data but report lock");

  a_des_drive_on: assert property (
    (st.ctrl.des_powerdown_n && st.ctrl.des_output_enable && st.rx_locked) |-> !st.des_data_oe_n && st.lock_out)
    else $error("locked receiver not driving outputs");

  a_lock_gain_run: assert property (
    $rose(st.rx_locked) |-> $past(st.rx_state) == RX_STOP && $past(st.rx_good) == `SLC_RX_LOCK_LAST)
    else $error("lock gained without a full run of good frames");

  a_lock_loss: assert property (
    (st.rx_state == RX_STOP && async_q.rx) |=> !st.rx_locked && st.des_data_oe_n && !st.lock_out)
    else $error("bad clock bit did not drop lock");

  a_rx_frame_width: assert property (
    (st.rx_state == RX_STOP) |-> st.rx_cnt == `SLC_RX_STOP_CNT && $past(st.rx_state, 50) == RX_DATA
                                 && $past(st.rx_state, 51) == RX_HUNT)
    else $error("frame length differs from 24 payload bits");

  a_rclk_launch: assert property (
    ($changed(st.des_parallel_out) && st.ctrl.rx_edge_select) |-> !st.rclk ##RCLK_DLY st.rclk)
    else $error("recovered clock does not rise after data launch");

  c_tx_frame:  cover property ($rose(st.tx_busy));
  c_rx_lock:   cover property ($rose(st.rx_locked));
  c_lock_loss: cover property ($fell(st.rx_locked));
  c_bus_write: cover property (avs_write && !st.wait_q && (avs_address == `SLC_CTRL_OFS));

endmodule

// ---- slc_far_ser.sv ----
/*
  Far-end serializer model that drives the serial line into the receiver.
  Assumes the bench calls send_frame right after a rising mclk edge.
*/
`timescale 1ns/100ps
`include "slc_defines.svh"

module slc_far_ser (
  input  wire logic mclk,
  output logic      line
);
  initial line = 1'b0;

  // Idle low, start 1, payload LSB first, stop; 2 mclk a bit
  task automatic send_frame(input logic [23:0] w, input logic scr_off, input logic bad, input int gap);
    logic [25:0] fr;
    fr = {bad, scr_off ? w : w ^ `SLC_SCR_MASK, 1'b1};
    for (int i = 0; i < 52; i++) begin
      line <= fr[i/2];
      @(posedge mclk);
    end
    // No training pattern: the stream simply runs
    line <= 1'b0;
    repeat (gap) @(posedge mclk);
  endtask
endmodule

// ---- slc_link_ctrl_tb.sv ----
/*
  Self-checking bench of the serial link control block.
  Assumes the design files and the far-end model are compiled first.
*/
`timescale 1ns/100ps
`include "slc_defines.svh"

module slc_link_ctrl_tb import slc_pkg::*;;
  typedef struct packed {
    logic        wr;
    logic [3:0]  a;
    logic [31:0] d;
    logic [3:0]  be;
    logic [31:0] exp;
  } slc_row_s;

  logic        mclk, rst, avs_read, avs_write, avs_waitrequest, pclk_run;
  logic        tx_pixel_clock, ser_in_ready, ser_out, ser_out_oe_n, serial_rx;
  logic        rclk_out, des_data_oe_n, lock_out, lock_oe_n;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [23:0] ser_din, des_parallel_out, got;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  slc_row_s    rows [9];

  slc_link_ctrl dut (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .tx_pixel_clock, .ser_din, .ser_in_ready, .ser_out, .ser_out_oe_n,
    .serial_rx, .des_parallel_out, .rclk_out, .des_data_oe_n, .lock_out, .lock_oe_n);
  slc_far_ser far (.mclk, .line(serial_rx));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Pixel clock free of mclk phase; stops low when gated
  initial begin
    tx_pixel_clock = 1'b0;
    #137;
    forever #400 tx_pixel_clock = pclk_run & ~tx_pixel_clock;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Held until waitrequest is sampled low; one idle edge before the next
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_bit(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) @(posedge mclk);
  endtask
  task automatic frame(input logic [23:0] e);
    wait_bit(ser_out, 1'b1, 400);
    for (int i = 0; i < 24; i++) begin
      repeat (2) @(posedge mclk);
      got[i] = ser_out;
    end
    repeat (2) @(posedge mclk);
    chk_bit("stop bit", 1'b0, ser_out);
    chk_word("payload", {8'h00, e}, {8'h00, got});
  endtask
  task automatic lock_up(input logic [23:0] w);
    repeat (4) far.send_frame(w, 1'b0, 1'b0, 1);
    wait_bit(lock_out, 1'b1, 20);
    @(posedge mclk);
  endtask

  initial begin
    {rst, pclk_run} = 2'b10;
    {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
    ser_din = 24'h3c_a51e;
    rows = '{'{1'b0, 4'h0, 32'h0, 4'hf, 32'h0000_006a}, '{1'b1, 4'h0, 32'h0000_007f, 4'h0, 32'h0},
             '{1'b0, 4'h0, 32'h0, 4'hf, 32'h0000_006a}, '{1'b1, 4'h0, 32'hffff_ff6a, 4'hf, 32'h0},
             '{1'b0, 4'h0, 32'h0, 4'hf, 32'h0000_006a}, '{1'b1, 4'hc, 32'hffff_ffff, 4'hf, 32'h0},
             '{1'b0, 4'hc, 32'h0, 4'hf, 32'h0}, '{1'b1, 4'h4, 32'hffff_ffff, 4'hf, 32'h0},
             '{1'b0, 4'h4, 32'h0, 4'hf, 32'h0000_0004}};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk_bit("ser oe_n", 1'b1, ser_out_oe_n);
    chk_bit("data oe_n", 1'b1, des_data_oe_n);
    chk_bit("lock oe_n", 1'b1, lock_oe_n);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d, rows[i].be);
      if (!rows[i].wr) chk_word("reg read", rows[i].exp, q);
    end
    // Serializer, legacy coding first
    pclk_run = 1'b1;
    bus(1'b1, 4'h0, 32'h0000_006f, 4'hf);
    wait_bit(ser_out_oe_n, 1'b0, 300);
    chk_bit("tx active", 1'b0, ser_out_oe_n);
    frame(24'h3c_a51e);
    chk_bit("buffer full", 1'b0, ser_in_ready);
    bus(1'b1, 4'h0, 32'h0000_006d, 4'hf);
    chk_bit("tx disabled", 1'b1, ser_out_oe_n);
    pclk_run = 1'b0;
    // Falling-edge pixel capture from here on
    bus(1'b1, 4'h0, 32'h0000_0063, 4'hf);
    repeat (40) @(posedge mclk);
    chk_bit("tx unlocked", 1'b1, ser_out_oe_n);
    pclk_run = 1'b1;
    frame(24'h3c_a51e ^ `SLC_SCR_MASK);
    // Deserializer from the far-end model
    bus(1'b1, 4'h0, 32'h0000_007a, 4'hf);
    repeat (3) far.send_frame(24'h81_2c47, 1'b0, 1'b0, 1);
    chk_bit("no lock yet", 1'b0, lock_out);
    chk_bit("lock driven", 1'b0, lock_oe_n);
    chk_bit("data floated", 1'b1, des_data_oe_n);
    far.send_frame(24'h81_2c47, 1'b0, 1'b0, 1);
    wait_bit(lock_out, 1'b1, 20);
    @(posedge mclk);
    chk_bit("lock", 1'b1, lock_out);
    chk_bit("data on", 1'b0, des_data_oe_n);
    chk_word("rx data", 32'h0081_2c47, {8'h00, des_parallel_out});
    far.send_frame(24'h5e_0d93, 1'b0, 1'b0, 30);
    chk_word("rx slow", 32'h005e_0d93, {8'h00, des_parallel_out});
    chk_bit("rclk high", 1'b1, rclk_out);
    bus(1'b1, 4'h0, 32'h0000_005a, 4'hf);
    chk_bit("data off", 1'b1, des_data_oe_n);
    chk_bit("lock still", 1'b1, lock_out);
    chk_bit("lock oe_n", 1'b0, lock_oe_n);
    bus(1'b1, 4'h0, 32'h0000_007a, 4'hf);
    // Bad stop bit drops lock
    far.send_frame(24'h5e_0d93, 1'b0, 1'b1, 8);
    chk_bit("lock lost", 1'b0, lock_out);
    chk_bit("data floats", 1'b1, des_data_oe_n);
    lock_up(24'h81_2c47);
    chk_bit("relock", 1'b1, lock_out);
    bus(1'b1, 4'h0, 32'h0000_007e, 4'hf);
    far.send_frame(24'h12_3456, 1'b1, 1'b0, 8);
    chk_word("legacy data", 32'h0012_3456, {8'h00, des_parallel_out});
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk_word("rx word", 32'h0012_3456, q);
    // Edge select low: clock rises with the data and is low again before the next word
    bus(1'b1, 4'h0, 32'h0000_003e, 4'hf);
    far.send_frame(24'h65_4321, 1'b1, 1'b0, 30);
    chk_word("rx fall mode", 32'h0065_4321, {8'h00, des_parallel_out});
    chk_bit("rclk low", 1'b0, rclk_out);
    bus(1'b1, 4'h0, 32'h0000_006a, 4'hf);
    chk_bit("lock off", 1'b1, lock_oe_n);
    chk_bit("data off", 1'b1, des_data_oe_n);
    end_of_test();
  end
endmodule
